// ### rcp_defs.svh
// Offsets, field positions, reset values and codes for the reset-cause and power-control block
`ifndef RCP_DEFS_SVH
`define RCP_DEFS_SVH

`define RCP_ADDR_W          12
`define RCP_GATE_ADDR       12'hf80
`define RCP_CAUSE_ADDR      12'hff0

`define RCP_GATE_RESET      8'h80
`define RCP_GATE_LPO_BIT    7
`define RCP_GATE_BO_BIT     4
`define RCP_GATE_TEMP_BIT   3
`define RCP_GATE_ADC_BIT    2
`define RCP_GATE_COMP_BIT   1
`define RCP_GATE_WR_MASK    8'h9e

`define RCP_CAUSE_POR_BIT   3
`define RCP_CAUSE_STOP_BIT  2
`define RCP_CAUSE_WDT_BIT   1
`define RCP_CAUSE_PIN_BIT   0
`define RCP_CAUSE_POR_VAL   4'h8
`define RCP_CAUSE_PIN_VAL   4'h1
`define RCP_CAUSE_WDT_VAL   4'h2
`define RCP_CAUSE_SMRP_VAL  4'h4
`define RCP_CAUSE_SMRW_VAL  4'h6
`define RCP_CAUSE_HI_LSB    4
`define RCP_LOW_SUPPLY_BIT  0

`define RCP_WDOG_RESET      8'h00

`endif

// ### rcp_pkg.sv
// Types shared by the reset-cause and power-control block
package rcp_pkg;

  // Reset or recovery source reported by the reset sequencer
  typedef enum logic [2:0] {
    RCP_CK_PIN_RESET = 3'h0,
    RCP_CK_WDT_RESET = 3'h1,
    RCP_CK_WDT_IRQ   = 3'h2,
    RCP_CK_DBG_RESET = 3'h3,
    RCP_CK_DBG_STOP  = 3'h4,
    RCP_CK_SMR_PIN   = 3'h5,
    RCP_CK_SMR_WDT   = 3'h6
  } rcp_cause_type;

  typedef enum logic [1:0] {
    RCP_ACTIVE = 2'b00,
    RCP_HALT   = 2'b01,
    RCP_STOP   = 2'b11
  } rcp_mode_type;

  typedef struct packed {
    logic irq;
    logic wdt_timeout;
    logic brownout_reset;
  } rcp_wake_type;

  typedef struct packed {
    logic temp;
    logic adc;
    logic comp;
  } rcp_blk_req_type;

  typedef struct packed {
    logic low_power_amp_off;
    logic brownout;
    logic temp;
    logic adc;
    logic comp;
  } rcp_blk_en_type;

  typedef struct packed {
    logic cpu_clk_en;
    logic pc_run;
    logic sys_clk_en;
    logic main_osc_en;
    logic xtal_pins_gpio;
    logic wdt_osc_run;
    logic wdt_run;
    logic periph_clk_en;
  } rcp_clk_ctrl_type;

endpackage

// ### rcp_sync2.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none

module rcp_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_val,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
    if (!rst_n) begin
      meta_d = reset_val;
      sync_d = reset_val;
    end
  end

  always_ff @(posedge core_clk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// ### rcp_top.sv
// Reset-cause recording, block power gating and halt/stop mode control
`timescale 1ns/1ps
`default_nettype none

`include "rcp_defs.svh"

// How it works
// - Reading the cause register clears only the upper flags that the read returns.
// - Cause address is read-only; writes there load the watchdog control register.
// - Power-on flag set by power-on, cleared by watchdog time-out or recovery.
// - Stop flag set on recovery, cleared by power-on or non-stop watchdog time-out.
// - Watchdog flag set on time-out, cleared by power-on or pin-change recovery.
// - Pin reset flag set by pin reset, cleared by power-on or pin-change recovery.
// - Bit 0 shows the live low-supply comparison gated by the brown-out detector enable, never latched.
// - Debugger reset or debug-pin stop reset leave only the power-on flag.
// - Watchdog stop recovery sets stop and watchdog flags, clears the others.
// - Stop halts CPU, system clock, oscillators; only enabled survivors run.
// - Entering stop hands the crystal pins back to their port settings.
// - Halt stops only the CPU and program counter.
// - Halt ends on interrupt, watchdog, power-on, brown-out or reset pin.
// - Each set gate bit disables its block by clock or power.
// - Brown-out detector runs only with gate bit 4 clear and the option enabling.
// - Gate register is initialised only by power-on reset.
// - A set gate bit overrides the block's own enable bits.
// - Enabled amplifier keeps running in stop mode.
module rcp_top
  import rcp_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   por_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`RCP_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   cause_valid,
  input  wire rcp_cause_type          cause_kind,
  input  wire logic                   halt_req,
  input  wire logic                   stop_req,
  input  wire rcp_wake_type           wake,
  input  wire logic                   reset_pin_n,
  input  wire logic                   low_supply_cmp,
  input  wire logic                   brownout_always_on_option,
  input  wire logic                   brownout_option_enable,
  input  wire logic                   wdt_osc_enable,
  input  wire logic                   wdt_enable,
  input  wire rcp_blk_req_type        blk_req,
  output logic      [7:0]             wdog_ctrl,
  output logic                        wdog_ctrl_wr,
  output rcp_mode_type                mode,
  output rcp_clk_ctrl_type            clk_ctrl,
  output rcp_blk_en_type              blk_en
);

  // Synchronised pin and comparator levels
  logic [1:0]       pin_sync;
  logic             reset_pin_s_n;
  logic             low_supply_s;

  logic             sys_rst;
  logic             wr_acc;
  logic             rd_acc;
  logic             setup_ph;

  logic [7:0]       gate_q;
  logic [7:0]       gate_d;
  logic [7:0]       wdog_q;
  logic [7:0]       wdog_d;
  logic             wdog_wr_q;
  logic             wdog_wr_d;
  logic [31:0]      rdata_q;
  logic [31:0]      rdata_d;
  logic             err_q;
  logic             err_d;
  logic [3:0]       cause_q;
  logic [3:0]       cause_d;
  rcp_mode_type     mode_q;
  rcp_mode_type     mode_d;
  rcp_clk_ctrl_type clk_q;
  rcp_clk_ctrl_type clk_d;
  rcp_blk_en_type   blk_q;
  rcp_blk_en_type   blk_d;

  function automatic logic addr_hit(input logic [`RCP_ADDR_W-1:0] a);
    addr_hit = (a == `RCP_GATE_ADDR) || (a == `RCP_CAUSE_ADDR);
  endfunction

  // Flag image after a cause event; flags the event leaves alone keep cur
  function automatic logic [3:0] cause_apply(input rcp_cause_type k, input logic [3:0] cur);
    logic [3:0] v;
    v = cur;
    unique case (k)
      RCP_CK_PIN_RESET: v = `RCP_CAUSE_PIN_VAL;
      RCP_CK_WDT_RESET: v = `RCP_CAUSE_WDT_VAL;
      RCP_CK_WDT_IRQ: begin
        v[`RCP_CAUSE_POR_BIT]  = 1'b0;
        v[`RCP_CAUSE_STOP_BIT] = 1'b0;
        v[`RCP_CAUSE_WDT_BIT]  = 1'b1;
      end
      RCP_CK_DBG_RESET: v = `RCP_CAUSE_POR_VAL;
      RCP_CK_DBG_STOP:  v = `RCP_CAUSE_POR_VAL;
      RCP_CK_SMR_PIN:   v = `RCP_CAUSE_SMRP_VAL;
      RCP_CK_SMR_WDT:   v = `RCP_CAUSE_SMRW_VAL;
      default:          v = cur;
    endcase
    cause_apply = v;
  endfunction

  rcp_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .async_in  ({reset_pin_n, low_supply_cmp}),
    .reset_val (2'b10),
    .sync_out  (pin_sync)
  );

  assign reset_pin_s_n = pin_sync[1];
  assign low_supply_s  = pin_sync[0];

  assign sys_rst  = !rst_n || !por_n;
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && penable && !pwrite;

  // Bus registers: power gate, watchdog control, read data
  always_comb begin
    gate_d    = gate_q;
    wdog_d    = wdog_q;
    wdog_wr_d = 1'b0;
    rdata_d   = rdata_q;
    err_d     = err_q;
    if (wr_acc && paddr == `RCP_GATE_ADDR) begin
      gate_d = pwdata[7:0] & `RCP_GATE_WR_MASK;
    end
    // write at cause address lands in watchdog control
    if (wr_acc && paddr == `RCP_CAUSE_ADDR) begin
      wdog_d    = pwdata[7:0];
      wdog_wr_d = 1'b1;
    end
    if (setup_ph) begin
      rdata_d = 32'h0000_0000;
      err_d   = !addr_hit(paddr);
      if (!pwrite && paddr == `RCP_GATE_ADDR) begin
        rdata_d[7:0] = gate_q;
      end
      // live low-supply bit, gated with the shared detector
      if (!pwrite && paddr == `RCP_CAUSE_ADDR) begin
        rdata_d[7:4]                 = cause_q;
        rdata_d[`RCP_LOW_SUPPLY_BIT] = low_supply_s && blk_q.brownout;
      end
    end
    if (sys_rst) begin
      wdog_d    = `RCP_WDOG_RESET;
      wdog_wr_d = 1'b0;
      rdata_d   = 32'h0000_0000;
      err_d     = 1'b0;
    end
    // only power-on reset initialises the gate
    if (!por_n) begin
      gate_d = `RCP_GATE_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    gate_q    <= gate_d;
    wdog_q    <= wdog_d;
    wdog_wr_q <= wdog_wr_d;
    rdata_q   <= rdata_d;
    err_q     <= err_d;
  end

  // Cause flags: only the flags returned by the read are cleared
  always_comb begin
    cause_d = cause_q;
    if (rd_acc && paddr == `RCP_CAUSE_ADDR) begin
      cause_d = cause_q & ~rdata_q[7:4];
    end
    if (cause_valid) begin
      cause_d = cause_apply(cause_kind, cause_d);
    end
    // power-on sets only its own flag
    if (!por_n) begin
      cause_d = `RCP_CAUSE_POR_VAL;
    end
  end

  always_ff @(posedge core_clk) begin
    cause_q <= cause_d;
  end

  // Mode machine
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      RCP_ACTIVE: begin
        if (stop_req) begin
          mode_d = RCP_STOP;
        end else if (halt_req) begin
          mode_d = RCP_HALT;
        end
      end
      RCP_HALT: begin
        if (wake.irq || wake.wdt_timeout || wake.brownout_reset || !reset_pin_s_n) begin
          mode_d = RCP_ACTIVE;
        end
      end
      RCP_STOP: begin
        if (cause_valid || !reset_pin_s_n) begin
          mode_d = RCP_ACTIVE;
        end
      end
      default: mode_d = RCP_ACTIVE;
    endcase
    if (sys_rst) begin
      mode_d = RCP_ACTIVE;
    end
  end

  always_ff @(posedge core_clk) begin
    mode_q <= mode_d;
  end

  // Clock and block enables follow the next mode and the gate
  always_comb begin
    clk_d.cpu_clk_en     = 1'b1;
    clk_d.pc_run         = 1'b1;
    clk_d.sys_clk_en     = 1'b1;
    clk_d.main_osc_en    = 1'b1;
    clk_d.xtal_pins_gpio = 1'b0;
    clk_d.wdt_osc_run    = wdt_osc_enable;
    clk_d.wdt_run        = wdt_enable;
    clk_d.periph_clk_en  = 1'b1;
    // halt stops CPU and program counter only
    if (mode_d == RCP_HALT) begin
      clk_d.cpu_clk_en = 1'b0;
      clk_d.pc_run     = 1'b0;
    end
    if (mode_d == RCP_STOP) begin
      clk_d.cpu_clk_en    = 1'b0;
      clk_d.pc_run        = 1'b0;
      clk_d.sys_clk_en    = 1'b0;
      clk_d.main_osc_en   = 1'b0;
      clk_d.periph_clk_en = 1'b0;
      // crystal pins fall back to port
      clk_d.xtal_pins_gpio = 1'b1;
    end
    blk_d.temp = !gate_d[`RCP_GATE_TEMP_BIT] && blk_req.temp && mode_d != RCP_STOP;
    blk_d.adc  = !gate_d[`RCP_GATE_ADC_BIT] && blk_req.adc && mode_d != RCP_STOP;
    blk_d.comp = !gate_d[`RCP_GATE_COMP_BIT] && blk_req.comp && mode_d != RCP_STOP;
    blk_d.low_power_amp_off  = !gate_d[`RCP_GATE_LPO_BIT];
    // gate bit and option must both enable
    blk_d.brownout = !gate_d[`RCP_GATE_BO_BIT] && brownout_option_enable &&
                     (mode_d != RCP_STOP || brownout_always_on_option);
  end

  always_ff @(posedge core_clk) begin
    clk_q <= clk_d;
    blk_q <= blk_d;
  end

  assign prdata       = rdata_q;
  assign pready       = 1'b1;
  assign pslverr      = err_q && psel && penable;
  assign wdog_ctrl    = wdog_q;
  assign wdog_ctrl_wr = wdog_wr_q;
  assign mode         = mode_q;
  assign clk_ctrl     = clk_q;
  assign blk_en       = blk_q;

endmodule

`default_nettype wire

// ### rcp_top_properties.sv
// Checker for the reset-cause and power-control block
`timescale 1ns/1ps
`default_nettype none
module rcp_props
  import rcp_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             rst_n,
  input wire logic             por_n,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire rcp_wake_type     wake,
  input wire logic [7:0]       wdog_ctrl,
  input wire logic             wdog_ctrl_wr,
  input wire rcp_mode_type     mode,
  input wire rcp_clk_ctrl_type clk_ctrl,
  input wire rcp_blk_en_type   blk_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n || !por_n);
  wire acc = psel && penable;
  ready_zero_wait_a: assert property (acc |-> pready) else $error("pready low in access");
  bad_addr_err_a: assert property (acc && paddr != 12'hf80 && paddr != 12'hff0 |-> pslverr)
    else $error("no error on unmapped");
  err_idle_a: assert property (!acc |-> !pslverr) else $error("error outside access");
  wdog_load_a: assert property (acc && pwrite && paddr == 12'hff0 |=>
    wdog_ctrl_wr && {24'h0, wdog_ctrl} == ($past(pwdata) & 32'h0000_00ff)) else $error("wdog not loaded");
  cause_pad_a: assert property (acc && !pwrite && paddr == 12'hff0 |->
    prdata[31:8] == 24'h0 && prdata[3:1] == 3'h0) else $error("cause pad bits set");
  stop_clocks_a: assert property (mode == RCP_STOP |-> !clk_ctrl.cpu_clk_en &&
    !clk_ctrl.sys_clk_en && !clk_ctrl.main_osc_en && !blk_en.adc) else $error("clock runs in stop");
  xtal_release_a: assert property (mode == RCP_STOP |-> clk_ctrl.xtal_pins_gpio) else $error("xtal kept");
  halt_clocks_a: assert property (mode == RCP_HALT |-> !clk_ctrl.cpu_clk_en &&
    !clk_ctrl.pc_run && clk_ctrl.sys_clk_en && clk_ctrl.main_osc_en) else $error("bad halt clocks");
  halt_wake_a: assert property (mode == RCP_HALT && wake.irq |=> mode == RCP_ACTIVE)
    else $error("no wake from halt");
  gate_off_a: assert property (acc && pwrite && paddr == 12'hf80 && pwdata[2] |-> ##2 !blk_en.adc)
    else $error("gated block runs");
endmodule
bind rcp_top rcp_props i_props (.core_clk, .rst_n, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .wake, .wdog_ctrl, .wdog_ctrl_wr, .mode, .clk_ctrl, .blk_en);
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the reset-cause and power-control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rcp_pkg::*;
  logic core_clk = 0, rst_n = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, err, cause_valid = 0, halt_req = 0, stop_req = 0;
  logic reset_pin_n = 1, low_supply_cmp = 0, wdog_ctrl_wr;
  rcp_cause_type cause_kind = RCP_CK_PIN_RESET;
  rcp_wake_type wake = '0;
  rcp_blk_req_type blk_req = 3'h7;
  logic [7:0] wdog_ctrl;
  rcp_mode_type mode;
  rcp_clk_ctrl_type clk_ctrl;
  rcp_blk_en_type blk_en;
  int fail_count = 0, n_checks = 0, cyc = 0;
  always #2.5 core_clk = ~core_clk;
  rcp_top i_dut (.core_clk, .rst_n, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cause_valid, .cause_kind, .halt_req, .stop_req, .wake, .reset_pin_n,
    .low_supply_cmp, .brownout_always_on_option(1'b1), .brownout_option_enable(1'b1),
    .wdt_osc_enable(1'b1), .wdt_enable(1'b1), .blk_req, .wdog_ctrl, .wdog_ctrl_wr, .mode,
    .clk_ctrl, .blk_en);
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop;
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Setup, access until pready, release, one idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk) penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk(nm, exp, rd);
  endtask
  task automatic ev(input rcp_cause_type k);
    cause_valid <= 1;
    cause_kind <= k;
    @(posedge core_clk) cause_valid <= 0;
    @(posedge core_clk);
  endtask
  task automatic t_reset;
    rdchk("gate", 12'hf80, 32'h80);
    chk("lpo", 0, blk_en.low_power_amp_off);
    rdchk("cause", 12'hff0, 32'h80);
    rdchk("cleared", 12'hff0, 32'h0);
  endtask
  task automatic t_gate;
    apb(1, 12'hf80, 32'h9e);
    rdchk("gate mask", 12'hf80, 32'h9e);
    chk("all off", 0, blk_en);
    apb(1, 12'hf80, 32'h10);
    rst_n <= 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    rdchk("gate kept", 12'hf80, 32'h10);
    chk("bo off", 0, blk_en.brownout);
    apb(1, 12'hf80, 32'h0);
    @(posedge core_clk);
    chk("all on", 32'h1f, blk_en);
  endtask
  task automatic t_cause;
    rcp_cause_type a [6] = '{RCP_CK_PIN_RESET, RCP_CK_WDT_RESET, RCP_CK_DBG_RESET,
      RCP_CK_SMR_PIN, RCP_CK_PIN_RESET, RCP_CK_PIN_RESET};
    rcp_cause_type b [6] = '{RCP_CK_SMR_PIN, RCP_CK_SMR_PIN, RCP_CK_SMR_WDT,
      RCP_CK_WDT_RESET, RCP_CK_DBG_STOP, RCP_CK_WDT_IRQ};
    logic [7:0] e [6] = '{8'h40, 8'h40, 8'h60, 8'h20, 8'h80, 8'h30};
    for (int i = 0; i < 6; i++) begin
      ev(a[i]);
      ev(b[i]);
      rdchk("flags", 12'hff0, {24'h0, e[i]});
    end
  endtask
  task automatic t_bus;
    apb(1, 12'hff0, 32'h5a);
    chk("wdog", 32'h5a, wdog_ctrl);
    rdchk("no cause", 12'hff0, 32'h0);
    rdchk("unmapped", 12'h100, 32'h0);
    chk("slverr", 1, err);
    low_supply_cmp <= 1;
    repeat (4) @(posedge core_clk);
    rdchk("low", 12'hff0, 32'h1);
    low_supply_cmp <= 0;
    repeat (4) @(posedge core_clk);
    rdchk("low gone", 12'hff0, 32'h0);
  endtask
  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      halt_req <= 1;
      @(posedge core_clk) halt_req <= 0;
      @(negedge core_clk);
      chk("halt clk", 32'h37, clk_ctrl);
      @(posedge core_clk);
      wake <= (i < 3) ? rcp_wake_type'(3'h1 << i) : '0;
      reset_pin_n <= (i != 3);
      repeat (4) @(posedge core_clk);
      wake <= '0;
      reset_pin_n <= 1;
      @(negedge core_clk);
      chk("woken", RCP_ACTIVE, mode);
      repeat (3) @(posedge core_clk);
    end
    stop_req <= 1;
    @(posedge core_clk) stop_req <= 0;
    @(negedge core_clk);
    chk("stop clk", 32'h0e, clk_ctrl);
    chk("stop blk", 32'h18, blk_en);
    @(posedge core_clk);
    ev(RCP_CK_SMR_PIN);
    chk("recovered", RCP_ACTIVE, mode);
    rdchk("stop flag", 12'hff0, 32'h40);
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1;
    por_n <= 1;
    @(posedge core_clk);
    t_reset;
    t_gate;
    t_cause;
    t_bus;
    t_modes;
    report_and_stop;
  end
endmodule
`default_nettype wire
